/* File: timer_access_pkg.sv */
// Shared constants and carriers for the timer debug and count access slice
`default_nettype none
package timer_access_pkg;

    localparam int unsigned ADDR_W = 6;

    // Register offsets
    localparam logic [5:0] OFS_DEBUG_CTRL  = 6'h0E;
    localparam logic [5:0] OFS_BYTE_LATCH  = 6'h0F;
    localparam logic [5:0] OFS_COUNT_LOW   = 6'h20;
    localparam logic [5:0] OFS_COUNT_HIGH  = 6'h21;

    // Field positions
    localparam int unsigned RUN_WHILE_DEBUG_HALTED_BIT = 0;

    // Values after reset
    localparam logic [7:0]  DEBUG_CTRL_RESET = 8'h00;
    localparam logic [7:0]  BYTE_LATCH_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [7:0]  RDATA_RESET      = 8'h00;

    // One peripheral bus access, CPU or debug port
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    // Count update offered by the counting engine
    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } count_update_s;

endpackage : timer_access_pkg
`default_nettype wire

/* File: wide_byte_latch.sv */
// Shared byte latch serving the 16-bit count register of the timer
`timescale 1ns/1ns
`default_nettype none
module wide_byte_latch (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       wr_latch,
    input  wire logic       wr_low,
    input  wire logic       rd_low,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] count_high,
    output logic      [7:0] latch
);

    logic [7:0] next_latch;

    always_comb begin
        next_latch = latch;
        // Low-byte write parks the byte until the high write commits
        if (wr_latch || wr_low) begin
            next_latch = wdata;
        end else if (rd_low) begin
            // Snapshot high byte so the pair reads atomically
            next_latch = count_high;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            latch <= timer_access_pkg::BYTE_LATCH_RESET;
        end else begin
            latch <= next_latch;
        end
    end

endmodule : wide_byte_latch
`default_nettype wire

/* File: timer_debug_count_access.sv */
// Debug control, shared byte latch and 16-bit count register of the timer
`timescale 1ns/1ns
`default_nettype none
module timer_debug_count_access (
    input  wire logic                           mclk,
    input  wire logic                           srst,
    input  wire timer_access_pkg::bus_req_s      bus_req,
    output logic                          [7:0] rdata,
    input  wire logic                           cpu_debug_halted,
    input  wire timer_access_pkg::count_update_s count_update,
    input  wire logic                           event_in,
    output logic                                timer_run,
    output logic                                event_accepted,
    output logic                          [15:0] count_value
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    logic       wr_debug;
    logic       wr_latch;
    logic       wr_low;
    logic       wr_high;
    logic       rd_low;
    logic [7:0] latch;
    logic       run_while_debug_halted;

    assign wr_debug = bus_req.wr && hit(bus_req.addr, timer_access_pkg::OFS_DEBUG_CTRL);
    assign wr_latch = bus_req.wr && hit(bus_req.addr, timer_access_pkg::OFS_BYTE_LATCH);
    assign wr_low   = bus_req.wr && hit(bus_req.addr, timer_access_pkg::OFS_COUNT_LOW);
    assign wr_high  = bus_req.wr && hit(bus_req.addr, timer_access_pkg::OFS_COUNT_HIGH);
    assign rd_low   = bus_req.rd && hit(bus_req.addr, timer_access_pkg::OFS_COUNT_LOW);

    ////////////////////////////////////////////////////////////////////////
    // Debug halt gating

    // Halted only when the CPU breaks and the run bit is clear
    assign timer_run      = !cpu_debug_halted || run_while_debug_halted;
    assign event_accepted = event_in && timer_run;

    ////////////////////////////////////////////////////////////////////////
    // Shared byte latch

    wide_byte_latch u_wide_byte_latch (
        .mclk       (mclk),
        .srst       (srst),
        .wr_latch   (wr_latch),
        .wr_low     (wr_low),
        .rd_low     (rd_low),
        .wdata      (bus_req.wdata),
        .count_high (count_value[15:8]),
        .latch      (latch)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic        next_run_while_debug_halted;
    logic [15:0] next_count_value;
    logic [7:0]  next_rdata;

    always_comb begin
        next_run_while_debug_halted = run_while_debug_halted;
        next_count_value            = count_value;
        next_rdata                  = timer_access_pkg::RDATA_RESET;
        if (wr_debug) begin
            next_run_while_debug_halted =
                bus_req.wdata[timer_access_pkg::RUN_WHILE_DEBUG_HALTED_BIT];
        end
        // Bus commit first, engine update only while running
        if (wr_high) begin
            next_count_value = {bus_req.wdata, latch};
        end else if (count_update.valid && timer_run) begin
            next_count_value = count_update.value;
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                timer_access_pkg::OFS_DEBUG_CTRL: begin
                    next_rdata = {7'h00, run_while_debug_halted};
                end
                timer_access_pkg::OFS_BYTE_LATCH: begin
                    next_rdata = latch;
                end
                timer_access_pkg::OFS_COUNT_LOW: begin
                    next_rdata = count_value[7:0];
                end
                timer_access_pkg::OFS_COUNT_HIGH: begin
                    next_rdata = latch;
                end
                default: begin
                    next_rdata = timer_access_pkg::RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            run_while_debug_halted <= timer_access_pkg::DEBUG_CTRL_RESET[0];
            count_value            <= timer_access_pkg::COUNT_RESET;
            rdata                  <= timer_access_pkg::RDATA_RESET;
        end else begin
            run_while_debug_halted <= next_run_while_debug_halted;
            count_value            <= next_count_value;
            rdata                  <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    AST_HALT_FREEZES_COUNT: assert property (
        (cpu_debug_halted && !run_while_debug_halted && !wr_high)
        |=> $stable(count_value))
        else $error("Count moved while halted in debug");

    AST_HALT_DROPS_EVENTS: assert property (
        (cpu_debug_halted && !run_while_debug_halted) |-> !event_accepted && !timer_run)
        else $error("Event passed while halted in debug");

    AST_RUN_IN_DEBUG: assert property (
        (cpu_debug_halted && run_while_debug_halted && count_update.valid && !wr_high)
        |=> count_value == $past(count_update.value))
        else $error("Count update lost while running in debug");

    AST_LOW_WRITE_ONLY_LATCH: assert property (
        (wr_low && !count_update.valid)
        |=> latch == $past(bus_req.wdata) && $stable(count_value))
        else $error("Low write did not just load the latch");

    AST_SHARED_LATCH_COMMIT: assert property (
        wr_latch ##1 (wr_high && !bus_req.rd)
        |=> count_value == {$past(bus_req.wdata), $past(bus_req.wdata, 2)})
        else $error("Latch write did not feed the high commit");

    AST_LATCH_AFTER_RESET: assert property (
        $fell(srst) |-> latch == timer_access_pkg::BYTE_LATCH_RESET)
        else $error("Latch not zero after reset");

    AST_LATCH_READBACK: assert property (
        wr_latch ##1 (bus_req.rd && bus_req.addr == timer_access_pkg::OFS_BYTE_LATCH
        && !bus_req.wr) |=> rdata == $past(bus_req.wdata, 2))
        else $error("Latch readback mismatch");

    AST_LOW_BYTE_READ: assert property (
        rd_low |=> rdata == $past(count_value[7:0]))
        else $error("Low byte read wrong");

    AST_WRITE_BEATS_UPDATE: assert property (
        (wr_high && count_update.valid)
        |=> count_value == {$past(bus_req.wdata), $past(latch)})
        else $error("Hardware update beat bus write");

    AST_ATOMIC_PAIR_READ: assert property (
        (rd_low && !bus_req.wr) ##1 (bus_req.rd && !bus_req.wr
        && bus_req.addr == timer_access_pkg::OFS_COUNT_HIGH)
        |=> rdata == $past(count_value[15:8], 2))
        else $error("High byte read not from snapshot");

    AST_HIGH_WRITE_COMMITS: assert property (
        wr_high |=> count_value == {$past(bus_req.wdata), $past(latch)})
        else $error("High write did not commit both bytes");

    AST_LOW_READ_SNAPSHOT: assert property (
        (rd_low && !bus_req.wr) |=> latch == $past(count_value[15:8]))
        else $error("Low read did not snapshot the high byte");

    AST_HIGH_READ_FROM_LATCH: assert property (
        (bus_req.rd && bus_req.addr == timer_access_pkg::OFS_COUNT_HIGH)
        |=> rdata == $past(latch))
        else $error("High byte read not taken from the latch");

    AST_DEBUG_READBACK: assert property (
        (bus_req.rd && bus_req.addr == timer_access_pkg::OFS_DEBUG_CTRL)
        |=> rdata == {7'h00, $past(run_while_debug_halted)})
        else $error("Debug control readback wrong");

    AST_RUN_BIT_WRITE: assert property (
        wr_debug |=> run_while_debug_halted
        == $past(bus_req.wdata[timer_access_pkg::RUN_WHILE_DEBUG_HALTED_BIT]))
        else $error("Run in debug bit did not take the write");

    AST_EVENTS_PASS_RUNNING: assert property (
        (!cpu_debug_halted || run_while_debug_halted) |-> event_accepted == event_in)
        else $error("Event dropped while the timer runs");

    AST_UPDATE_WHILE_RUNNING: assert property (
        (!cpu_debug_halted && count_update.valid && !wr_high)
        |=> count_value == $past(count_update.value))
        else $error("Count update lost while the CPU runs");

    ////////////////////////////////////////////////////////////////////////
    // Scenario coverage


    COV_HALT_WITH_UPDATE: cover property (
        cpu_debug_halted && !run_while_debug_halted && count_update.valid);
    COV_RUN_IN_DEBUG: cover property (
        cpu_debug_halted && run_while_debug_halted && count_update.valid);
    COV_WRITE_PAIR: cover property (wr_low ##1 wr_high);
    COV_WRITE_VS_UPDATE: cover property (wr_high && count_update.valid);
    COV_READ_PAIR: cover property (rd_low ##1 (bus_req.rd
        && bus_req.addr == timer_access_pkg::OFS_COUNT_HIGH));

endmodule : timer_debug_count_access
`default_nettype wire

/* File: timer_debug_count_access_tb.sv */
// Self-checking bench for the timer debug and count access slice
`timescale 1ns/1ns
`default_nettype none
module timer_debug_count_access_tb;
    logic                            mclk             = 1'b0;
    logic                            srst             = 1'b1;
    timer_access_pkg::bus_req_s      bus_req          = '0;
    timer_access_pkg::count_update_s count_update     = '0;
    logic                            cpu_debug_halted = 1'b0;
    logic                            event_in         = 1'b0;
    logic                      [7:0] rdata;
    logic                            timer_run;
    logic                            event_accepted;
    logic                     [15:0] count_value;
    logic                      [7:0] rd_first;
    logic                      [7:0] rd_second;
    int                              error_cnt        = 0;
    int                              compares         = 0;

    always #20 mclk = ~mclk;

    timer_debug_count_access u_timer_debug_count_access (
        .mclk             (mclk),
        .srst             (srst),
        .bus_req          (bus_req),
        .rdata            (rdata),
        .cpu_debug_halted (cpu_debug_halted),
        .count_update     (count_update),
        .event_in         (event_in),
        .timer_run        (timer_run),
        .event_accepted   (event_accepted),
        .count_value      (count_value)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge mclk);
        bus_req <= '0;
        #1;
    endtask : access

    task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp, input string what);
        access(a, 8'h00, 1'b0, 1'b1);
        cmp(what, {8'h00, exp}, {8'h00, rdata});
    endtask : rd_reg

    // Two accesses on consecutive cycles; read data of each is kept
    task automatic pair(input logic [5:0] a0, input logic [7:0] d0, input logic w0,
                        input logic [5:0] a1, input logic [7:0] d1, input logic w1);
        @(posedge mclk);
        bus_req <= '{addr: a0, wdata: d0, wr: w0, rd: !w0};
        @(posedge mclk);
        bus_req <= '{addr: a1, wdata: d1, wr: w1, rd: !w1};
        #1;
        rd_first = rdata;
        @(posedge mclk);
        bus_req <= '0;
        #1;
        rd_second = rdata;
    endtask : pair

    task automatic update(input logic [15:0] v);
        @(posedge mclk);
        count_update <= '{valid: 1'b1, value: v};
        @(posedge mclk);
        count_update <= '0;
        #1;
    endtask : update

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rd_reg(6'h0E, 8'h00, "debug control reset");
        rd_reg(6'h0F, 8'h00, "latch reset");
        cmp("count reset", 16'h0000, count_value);
        access(6'h0F, 8'hA5, 1'b1, 1'b0);
        rd_reg(6'h0F, 8'hA5, "latch readback");
        access(6'h10, 8'h77, 1'b1, 1'b0);
        rd_reg(6'h10, 8'h00, "unmapped read");
        $display("test registers done");
        access(6'h20, 8'h34, 1'b1, 1'b0);
        cmp("count after low write", 16'h0000, count_value);
        rd_reg(6'h0F, 8'h34, "latch holds low byte");
        access(6'h21, 8'h12, 1'b1, 1'b0);
        cmp("count after high write", 16'h1234, count_value);
        rd_reg(6'h20, 8'h34, "count low");
        update(16'hBEEF);
        cmp("count after update", 16'hBEEF, count_value);
        rd_reg(6'h21, 8'h12, "count high snapshot");
        rd_reg(6'h20, 8'hEF, "count low new");
        rd_reg(6'h21, 8'hBE, "count high new");
        $display("test count access done");
        @(posedge mclk);
        cpu_debug_halted <= 1'b1;
        event_in         <= 1'b1;
        #1;
        cmp("halted run", 16'h0000, {15'h0, timer_run});
        cmp("halted event", 16'h0000, {15'h0, event_accepted});
        update(16'h1111);
        cmp("count frozen", 16'hBEEF, count_value);
        access(6'h0E, 8'hFF, 1'b1, 1'b0);
        rd_reg(6'h0E, 8'h01, "debug control");
        cmp("debug run", 16'h0001, {15'h0, timer_run});
        cmp("debug event", 16'h0001, {15'h0, event_accepted});
        update(16'h2222);
        cmp("count while halted", 16'h2222, count_value);
        access(6'h0E, 8'h00, 1'b1, 1'b0);
        cmp("run bit cleared", 16'h0000, {15'h0, timer_run});
        $display("test debug halt done");
        @(posedge mclk);
        cpu_debug_halted <= 1'b0;
        access(6'h0F, 8'hCD, 1'b1, 1'b0);
        @(posedge mclk);
        bus_req      <= '{addr: 6'h21, wdata: 8'hAB, wr: 1'b1, rd: 1'b0};
        count_update <= '{valid: 1'b1, value: 16'h3333};
        @(posedge mclk);
        bus_req      <= '0;
        count_update <= '0;
        #1;
        cmp("write beats update", 16'hABCD, count_value);
        $display("test write priority done");
        pair(6'h0F, 8'h56, 1'b1, 6'h21, 8'h78, 1'b1);
        cmp("latch then high commit", 16'h7856, count_value);
        pair(6'h20, 8'h9A, 1'b1, 6'h21, 8'hBC, 1'b1);
        cmp("back to back pair write", 16'hBC9A, count_value);
        pair(6'h0F, 8'h5A, 1'b1, 6'h0F, 8'h00, 1'b0);
        cmp("latch back to back readback", 16'h005A, {8'h00, rd_second});
        pair(6'h20, 8'h00, 1'b0, 6'h21, 8'h00, 1'b0);
        cmp("pair read low", 16'h009A, {8'h00, rd_first});
        cmp("pair read high", 16'h00BC, {8'h00, rd_second});
        $display("test back to back done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        cmp("count second reset", 16'h0000, count_value);
        rd_reg(6'h0F, 8'h00, "latch second reset");
        $display("test second reset done");
        report_and_stop();
    end
endmodule : timer_debug_count_access_tb
`default_nettype wire
